// ---- tmr_map.svh ----
// register offsets, field positions, reset values and divider counts of the timer
`ifndef TMR_MAP_SVH
`define TMR_MAP_SVH

`define TMR_ADDR_W       3
`define TMR_OFF_CTRL     3'h0
`define TMR_OFF_CLKSEL   3'h1
`define TMR_OFF_CNT_LO   3'h2
`define TMR_OFF_CNT_HI   3'h3
`define TMR_OFF_RLD_LO   3'h4
`define TMR_OFF_RLD_HI   3'h5
`define TMR_OFF_IRQ_EN   3'h6

`define TMR_BIT_HF       7
`define TMR_BIT_LF       6
`define TMR_BIT_LIEN     5
`define TMR_BIT_CEN      4
`define TMR_BIT_SPLIT    3
`define TMR_BIT_RUN      2
`define TMR_BIT_UNUSED   1
`define TMR_BIT_XCLK     0
`define TMR_BIT_FAST_LO  0
`define TMR_BIT_FAST_HI  1
`define TMR_BIT_IRQ_EN   0

`define TMR_BYTE_RST     8'h00
`define TMR_BYTE_MAX     8'hFF
`define TMR_DIV_SLOW     12
`define TMR_DIV_EXT      8

`endif

// ---- tmr_pkg.sv ----
// types shared by the timer modules
package tmr_pkg;
  typedef logic [7:0] tmr_byte_t;
  typedef enum logic [2:0] {
    TMR_M16   = 3'b001,
    TMR_SPLIT = 3'b010,
    TMR_CAPT  = 3'b100
  } tmr_mode_e;
endpackage

// ---- tmr_rise_sync.sv ----
// two-flop synchroniser with rising edge pulse
`timescale 1ns/10ps
module tmr_rise_sync (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic async_in,
  output logic      rise_pulse
);
  logic meta_r;
  logic sync_r;
  logic last_r;

  // synchroniser chain plus one history stage
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  // edge seen only on synchronised stages
  assign rise_pulse = sync_r & ~last_r;
endmodule

// ---- tmr_prescale.sv ----
// slow tick dividers: system clock by 12 and external edges by 8
`timescale 1ns/10ps
`include "tmr_map.svh"
module tmr_prescale #(
  parameter int DIV_SLOW = `TMR_DIV_SLOW,
  parameter int DIV_EXT  = `TMR_DIV_EXT
) (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic ext_rise,
  output logic      slow_tick,
  output logic      ext_tick
);
  localparam logic [3:0] SLOW_LAST = 4'(DIV_SLOW - 1);
  localparam logic [3:0] EXT_LAST  = 4'(DIV_EXT - 1);
  logic [3:0] slow_cnt_r;
  logic [3:0] ext_cnt_r;

  // system clock divider, one-cycle pulse per period
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      slow_cnt_r <= 4'h0;
      slow_tick  <= 1'b0;
    end else begin
      slow_tick  <= (slow_cnt_r == SLOW_LAST);
      slow_cnt_r <= (slow_cnt_r == SLOW_LAST) ? 4'h0 : slow_cnt_r + 4'h1;
    end
  end

  // external edges counted after synchronisation
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_cnt_r <= 4'h0;
      ext_tick  <= 1'b0;
    end else begin
      ext_tick <= ext_rise && (ext_cnt_r == EXT_LAST);
      if (ext_rise) begin
        ext_cnt_r <= (ext_cnt_r == EXT_LAST) ? 4'h0 : ext_cnt_r + 4'h1;
      end
    end
  end
endmodule

// ---- tmr_timer.sv ----
// auto-reload timer with split and comparator capture modes
//
// Notes on behaviour
// - count is two separately accessible bytes
// - split bit picks 16-bit or two 8-bit
// - sources system clock, divided 12, external 8
// - external divided tick synchronised to system clock
// - 16-bit rollover reloads, or wraps to zero in capture, and sets high flag
// - 16-bit overflow requests interrupt when enabled
// - low byte rollover also interrupts with enable
// - split bytes reload from own reload bytes
// - split run bit gates high byte only
// - per-byte fast select, else external select
// - split sets each flag on byte rollover
// - split interrupt on high, low if enabled
// - flags cleared only by software writes
// - capture only with capture set, split clear
// - comparator rise copies count, sets high flag
// - low flag set on low rollover always
// - 16-bit mode counts only while running
// - control bit one reads zero, ignores writes
`timescale 1ns/10ps
`include "tmr_map.svh"
module tmr_timer
  import tmr_pkg::*;
#(
  parameter int DIV_SLOW = `TMR_DIV_SLOW,
  parameter int DIV_EXT  = `TMR_DIV_EXT
) (
  input  wire logic                   mclk,
  input  wire logic                   sys_rst,
  input  wire logic [`TMR_ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_we,
  input  wire logic                   reg_re,
  output logic      [7:0]             reg_rdata,
  input  wire logic                   ext_osc_in,
  input  wire logic                   cmp_out_in,
  output logic                        timer_irq
);

  ////////////////////////////////////////////////////////////////////
  // decoding helpers

  // mode from split and capture bits
  function automatic tmr_mode_e mode_of(input logic split, input logic cen);
    if (split) begin
      return TMR_SPLIT;
    end
    return cen ? TMR_CAPT : TMR_M16;
  endfunction

  // tick of one byte from its fast and external selects
  function automatic logic sel_tick(input logic fast, input logic xclk,
                                    input logic slow, input logic ext8);
    if (fast) begin
      return 1'b1;
    end
    return xclk ? ext8 : slow;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // state

  logic      high_overflow_flag_r;
  logic      low_overflow_flag_r;
  logic      low_byte_irq_enable_r;
  logic      capture_enable_r;
  logic      split_mode_select_r;
  logic      run_control_r;
  logic      external_clock_select_r;
  logic      high_byte_fast_clock_select_r;
  logic      low_byte_fast_clock_select_r;
  logic      timer_irq_enable_r;
  tmr_byte_t count_low_byte_r;
  tmr_byte_t count_high_byte_r;
  tmr_byte_t reload_low_byte_r;
  tmr_byte_t reload_high_byte_r;
  tmr_byte_t rdata_r;
  logic      irq_r;

  logic      ext_rise;
  logic      cmp_rise;
  logic      slow_tick;
  logic      ext_tick;
  tmr_mode_e mode;
  logic      wide;
  logic      xclk_eff;
  logic      tick_lo;
  logic      tick_hi;
  logic      inc_lo;
  logic      inc_hi;
  logic      ovf_lo;
  logic      ovf_hi;
  logic      cap_evt;
  logic      wr_ctrl;
  logic      wr_cnt_lo;
  logic      wr_cnt_hi;
  tmr_byte_t cnt_lo_nxt;
  tmr_byte_t cnt_hi_nxt;
  tmr_byte_t ctrl_rd;

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers and tick dividers

  tmr_rise_sync u_ext_sync (
    .mclk       (mclk),
    .sys_rst    (sys_rst),
    .async_in   (ext_osc_in),
    .rise_pulse (ext_rise)
  );

  tmr_rise_sync u_cmp_sync (
    .mclk       (mclk),
    .sys_rst    (sys_rst),
    .async_in   (cmp_out_in),
    .rise_pulse (cmp_rise)
  );

  tmr_prescale #(
    .DIV_SLOW (DIV_SLOW),
    .DIV_EXT  (DIV_EXT)
  ) u_prescale (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .ext_rise  (ext_rise),
    .slow_tick (slow_tick),
    .ext_tick  (ext_tick)
  );

  ////////////////////////////////////////////////////////////////////
  // mode, ticks and overflow events

  // capture mode needs split clear
  assign mode     = mode_of(split_mode_select_r, capture_enable_r);
  assign wide     = (mode != TMR_SPLIT);
  // capture counts only from system clock or divided 12
  assign xclk_eff = external_clock_select_r & (mode != TMR_CAPT);
  // per-byte source selection
  assign tick_lo  = sel_tick(low_byte_fast_clock_select_r, xclk_eff,
                             slow_tick, ext_tick);
  assign tick_hi  = sel_tick(high_byte_fast_clock_select_r, xclk_eff,
                             slow_tick, ext_tick);
  // wide modes gated by run, split low byte free-running
  assign inc_lo   = wide ? (run_control_r & tick_lo) : tick_lo;
  assign inc_hi   = wide ? (inc_lo & (count_low_byte_r == `TMR_BYTE_MAX))
                         : (run_control_r & tick_hi);
  assign ovf_lo   = inc_lo & (count_low_byte_r == `TMR_BYTE_MAX);
  assign ovf_hi   = inc_hi & (count_high_byte_r == `TMR_BYTE_MAX);
  assign cap_evt  = (mode == TMR_CAPT) & cmp_rise;

  assign wr_ctrl   = reg_we && (reg_addr == `TMR_OFF_CTRL);
  assign wr_cnt_lo = reg_we && (reg_addr == `TMR_OFF_CNT_LO);
  assign wr_cnt_hi = reg_we && (reg_addr == `TMR_OFF_CNT_HI);

  // next low byte: reload on the owning overflow outside capture, else step by one
  always_comb begin
    cnt_lo_nxt = count_low_byte_r + 8'h01;
    if (ovf_lo) begin
      if (mode == TMR_SPLIT || (mode == TMR_M16 && ovf_hi)) begin
        cnt_lo_nxt = reload_low_byte_r;
      end else begin
        cnt_lo_nxt = `TMR_BYTE_RST;
      end
    end
  end

  // next high byte, capture mode wraps to zero
  always_comb begin
    cnt_hi_nxt = count_high_byte_r + 8'h01;
    if (ovf_hi) begin
      cnt_hi_nxt = (mode == TMR_CAPT) ? `TMR_BYTE_RST
                                      : reload_high_byte_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // count bytes, software write wins over a tick

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      count_low_byte_r <= `TMR_BYTE_RST;
    end else if (wr_cnt_lo) begin
      count_low_byte_r <= reg_wdata;
    end else if (inc_lo) begin
      count_low_byte_r <= cnt_lo_nxt;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      count_high_byte_r <= `TMR_BYTE_RST;
    end else if (wr_cnt_hi) begin
      count_high_byte_r <= reg_wdata;
    end else if (inc_hi) begin
      count_high_byte_r <= cnt_hi_nxt;
    end
  end

  // reload bytes, capture wins over a software write
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      reload_low_byte_r  <= `TMR_BYTE_RST;
      reload_high_byte_r <= `TMR_BYTE_RST;
    end else if (cap_evt) begin
      reload_low_byte_r  <= count_low_byte_r;
      reload_high_byte_r <= count_high_byte_r;
    end else if (reg_we) begin
      if (reg_addr == `TMR_OFF_RLD_LO) begin
        reload_low_byte_r <= reg_wdata;
      end
      if (reg_addr == `TMR_OFF_RLD_HI) begin
        reload_high_byte_r <= reg_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // control and clock-select registers

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      low_byte_irq_enable_r   <= 1'b0;
      capture_enable_r        <= 1'b0;
      split_mode_select_r     <= 1'b0;
      run_control_r           <= 1'b0;
      external_clock_select_r <= 1'b0;
    end else if (wr_ctrl) begin
      low_byte_irq_enable_r   <= reg_wdata[`TMR_BIT_LIEN];
      capture_enable_r        <= reg_wdata[`TMR_BIT_CEN];
      split_mode_select_r     <= reg_wdata[`TMR_BIT_SPLIT];
      run_control_r           <= reg_wdata[`TMR_BIT_RUN];
      external_clock_select_r <= reg_wdata[`TMR_BIT_XCLK];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      high_byte_fast_clock_select_r <= 1'b0;
      low_byte_fast_clock_select_r  <= 1'b0;
      timer_irq_enable_r            <= 1'b0;
    end else if (reg_we) begin
      if (reg_addr == `TMR_OFF_CLKSEL) begin
        high_byte_fast_clock_select_r <= reg_wdata[`TMR_BIT_FAST_HI];
        low_byte_fast_clock_select_r  <= reg_wdata[`TMR_BIT_FAST_LO];
      end
      if (reg_addr == `TMR_OFF_IRQ_EN) begin
        timer_irq_enable_r <= reg_wdata[`TMR_BIT_IRQ_EN];
      end
    end
  end

  // sticky flags, hardware set wins over software clear
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      high_overflow_flag_r <= 1'b0;
      low_overflow_flag_r  <= 1'b0;
    end else begin
      if (ovf_hi || cap_evt) begin
        high_overflow_flag_r <= 1'b1;
      end else if (wr_ctrl) begin
        high_overflow_flag_r <= reg_wdata[`TMR_BIT_HF];
      end
      if (ovf_lo) begin
        low_overflow_flag_r <= 1'b1;
      end else if (wr_ctrl) begin
        low_overflow_flag_r <= reg_wdata[`TMR_BIT_LF];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // interrupt request and read port

  // enable-gated flags, held until software clears
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= timer_irq_enable_r & (high_overflow_flag_r |
               (low_byte_irq_enable_r & low_overflow_flag_r));
    end
  end

  // unused control bit always zero
  assign ctrl_rd = {high_overflow_flag_r, low_overflow_flag_r,
                    low_byte_irq_enable_r, capture_enable_r,
                    split_mode_select_r, run_control_r, 1'b0,
                    external_clock_select_r};

  // read data valid one cycle after the strobe, zero otherwise
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_r <= `TMR_BYTE_RST;
    end else if (reg_re) begin
      case (reg_addr)
        `TMR_OFF_CTRL: begin
          rdata_r <= ctrl_rd;
        end
        `TMR_OFF_CLKSEL: begin
          rdata_r <= {6'h00, high_byte_fast_clock_select_r,
                      low_byte_fast_clock_select_r};
        end
        `TMR_OFF_CNT_LO: begin
          rdata_r <= count_low_byte_r;
        end
        `TMR_OFF_CNT_HI: begin
          rdata_r <= count_high_byte_r;
        end
        `TMR_OFF_RLD_LO: begin
          rdata_r <= reload_low_byte_r;
        end
        `TMR_OFF_RLD_HI: begin
          rdata_r <= reload_high_byte_r;
        end
        `TMR_OFF_IRQ_EN: begin
          rdata_r <= {7'h00, timer_irq_enable_r};
        end
        default: begin
          rdata_r <= `TMR_BYTE_RST;
        end
      endcase
    end else begin
      rdata_r <= `TMR_BYTE_RST;
    end
  end

  assign reg_rdata = rdata_r;
  assign timer_irq = irq_r;

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  chk_unused_bit_zero: assert property (
    reg_re && reg_addr == `TMR_OFF_CTRL |=> !reg_rdata[`TMR_BIT_UNUSED])
    else $error("unused control bit read nonzero");

  chk_wide_reload: assert property (
    mode == TMR_M16 && ovf_hi && !wr_cnt_lo && !wr_cnt_hi && !cap_evt
    |=> {count_high_byte_r, count_low_byte_r} ==
        {$past(reload_high_byte_r), $past(reload_low_byte_r)}
        && high_overflow_flag_r)
    else $error("16-bit overflow did not reload");

  chk_split_low_free: assert property (
    mode == TMR_SPLIT && !run_control_r && tick_lo && !wr_cnt_lo
    && count_low_byte_r != `TMR_BYTE_MAX
    |=> count_low_byte_r == $past(count_low_byte_r) + 8'h01)
    else $error("split low byte did not run");

  chk_stopped_hold: assert property (
    wide && !run_control_r && !reg_we
    |=> $stable(count_low_byte_r) && $stable(count_high_byte_r))
    else $error("stopped timer changed count");

  chk_split_high_rld: assert property (
    mode == TMR_SPLIT && ovf_hi && !wr_cnt_hi
    |=> count_high_byte_r == $past(reload_high_byte_r))
    else $error("split high byte did not reload");

  chk_low_flag_set: assert property (
    ovf_lo |=> low_overflow_flag_r)
    else $error("low rollover left flag clear");

  chk_flag_sticky: assert property (
    high_overflow_flag_r && !(wr_ctrl && !reg_wdata[`TMR_BIT_HF]) |=> high_overflow_flag_r)
    else $error("high flag cleared without write");

  chk_capture_copy: assert property (
    cap_evt |=> reload_low_byte_r == $past(count_low_byte_r)
            && reload_high_byte_r == $past(count_high_byte_r)
            && high_overflow_flag_r)
    else $error("capture did not copy count");

  chk_irq_gate: assert property (
    timer_irq_enable_r && high_overflow_flag_r && !reg_we |=> timer_irq)
    else $error("interrupt not raised for high flag");

  chk_irq_masked: assert property (
    !timer_irq_enable_r && !reg_we |=> !timer_irq)
    else $error("interrupt raised while disabled");

endmodule

// ---- tmr_far_side.sv ----
// far side model: external oscillator pin and comparator output
`timescale 1ns/10ps
module tmr_far_side (
  input  wire logic osc_on,
  input  wire logic cmp_req,
  output logic      ext_osc_in,
  output logic      cmp_out_in
);
  // oscillator runs only within a burst and rests low between bursts
  initial begin
    ext_osc_in = 1'b0;
    forever begin
      #70;
      ext_osc_in = osc_on ? ~ext_osc_in : 1'b0;
    end
  end
  // comparator edges lag the request and stay far slower than the timer clock
  initial cmp_out_in = 1'b0;
  always @(cmp_req) cmp_out_in <= #13 cmp_req;
endmodule

// ---- tmr_timer_bench.sv ----
// self-checking bench for the auto-reload timer
`timescale 1ns/10ps
`include "tmr_map.svh"
module tmr_timer_bench;
  import tmr_pkg::*;
  logic                   mclk;
  logic                   sys_rst;
  logic [`TMR_ADDR_W-1:0] reg_addr;
  logic [7:0]             reg_wdata;
  logic                   reg_we;
  logic                   reg_re;
  logic [7:0]             reg_rdata;
  logic                   ext_osc_in;
  logic                   cmp_out_in;
  logic                   timer_irq;
  logic                   osc_on;
  logic                   cmp_req;
  int                     failures;
  int                     n_tests;
  int                     cycles;
  logic [31:0]            lfsr_r;
  tmr_byte_t              rd_v;
  tmr_byte_t              rl_lo;
  tmr_byte_t              rl_hi;
  tmr_byte_t              k;
  logic [15:0]            cap_v;
  logic [15:0]            cnt_v;

  ////////////////////////////////////////////////////////////////////////
  // clock, design and far side
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  tmr_timer dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .ext_osc_in(ext_osc_in), .cmp_out_in(cmp_out_in), .timer_irq(timer_irq));
  tmr_far_side far (.osc_on(osc_on), .cmp_req(cmp_req), .ext_osc_in(ext_osc_in),
    .cmp_out_in(cmp_out_in));

  ////////////////////////////////////////////////////////////////////////
  // expectation helpers and bus tasks
  function automatic logic [31:0] lfsr_next(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // 16-bit count after a rollover from ffff and n further ticks
  function automatic logic [15:0] after_wrap(logic [15:0] rld, int n);
    return rld + 16'(n);
  endfunction
  task automatic rnd(output tmr_byte_t v);
    lfsr_r = lfsr_next(lfsr_next(lfsr_r));
    v = lfsr_r[7:0];
  endtask
  task automatic wr(input logic [2:0] a, input tmr_byte_t d);
    @(posedge mclk);
    reg_we    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_we <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge mclk);
    reg_re   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_re <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdchk(input logic [2:0] a, input tmr_byte_t e, input string nm);
    rd(a);
    chk(nm, 16'(e), 16'(rd_v));
  endtask
  task automatic complete_run;
    if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    lfsr_r = 32'h0000_0A7E;
    sys_rst = 1'b1;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_we = 1'b0;
    reg_re = 1'b0;
    osc_on = 1'b0;
    cmp_req = 1'b0;
    failures = 0;
    n_tests = 0;
    cycles = 0;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    // reset values, unused bit, unmapped index
    for (int i = 0; i < 8; i++) rdchk(3'(i), 8'h00, "reset value");
    wr(`TMR_OFF_CTRL, 8'h02);
    rdchk(`TMR_OFF_CTRL, 8'h00, "ctrl bit1");
    wr(3'h7, 8'hFF);
    rdchk(3'h7, 8'h00, "unmapped");
    // halted count keeps both written bytes
    rnd(rl_lo);
    rnd(rl_hi);
    wr(`TMR_OFF_CNT_LO, rl_lo);
    wr(`TMR_OFF_CNT_HI, rl_hi);
    repeat (20) @(posedge mclk);
    rdchk(`TMR_OFF_CNT_LO, rl_lo, "count lo");
    rdchk(`TMR_OFF_CNT_HI, rl_hi, "count hi");
    // 16-bit rollover with random reload and run length
    for (int n = 0; n < 4; n++) begin
      rnd(rl_lo);
      rnd(rl_hi);
      rnd(k);
      k = k & 8'h03;
      wr(`TMR_OFF_CLKSEL, 8'h01);
      wr(`TMR_OFF_RLD_LO, rl_lo);
      wr(`TMR_OFF_RLD_HI, rl_hi & 8'h7F);
      wr(`TMR_OFF_CNT_LO, 8'hFF);
      wr(`TMR_OFF_CNT_HI, 8'hFF);
      wr(`TMR_OFF_IRQ_EN, 8'h01);
      wr(`TMR_OFF_CTRL, 8'h04);
      repeat (k) @(posedge mclk);
      // flags looked at while running, then stop writing ones to keep them
      rdchk(`TMR_OFF_CTRL, 8'hC4, "wrap flags");
      wr(`TMR_OFF_CTRL, 8'hC0);
      rd(`TMR_OFF_CNT_LO);
      cnt_v[7:0] = rd_v;
      rd(`TMR_OFF_CNT_HI);
      cnt_v[15:8] = rd_v;
      chk("wrap count", after_wrap({rl_hi & 8'h7F, rl_lo}, k + 3), cnt_v);
      chk("wrap irq", 16'h1, 16'(timer_irq));
      wr(`TMR_OFF_CTRL, 8'h00);
      repeat (2) @(posedge mclk);
      chk("irq cleared", 16'h0, 16'(timer_irq));
    end
    // low byte rollover alone interrupts with its enable set, then clearing the timer enable masks it
    wr(`TMR_OFF_CNT_LO, 8'hFF);
    wr(`TMR_OFF_CNT_HI, 8'h00);
    wr(`TMR_OFF_CTRL, 8'h24);
    rdchk(`TMR_OFF_CTRL, 8'h64, "low flag");
    chk("low irq", 16'h1, 16'(timer_irq));
    wr(`TMR_OFF_IRQ_EN, 8'h00);
    repeat (2) @(posedge mclk);
    chk("irq masked", 16'h0, 16'(timer_irq));
    wr(`TMR_OFF_CTRL, 8'h00);
    wr(`TMR_OFF_IRQ_EN, 8'h01);
    // split mode: low free runs, high waits for run
    rnd(rl_lo);
    wr(`TMR_OFF_CLKSEL, 8'h03);
    wr(`TMR_OFF_RLD_LO, rl_lo);
    wr(`TMR_OFF_RLD_HI, 8'h5A);
    wr(`TMR_OFF_CNT_HI, 8'hFF);
    wr(`TMR_OFF_CNT_LO, 8'hFF);
    wr(`TMR_OFF_CTRL, 8'h08);
    repeat (10) @(posedge mclk);
    rdchk(`TMR_OFF_CNT_HI, 8'hFF, "split hi idle");
    rdchk(`TMR_OFF_CTRL, 8'h48, "split lo flag");
    chk("split no irq", 16'h0, 16'(timer_irq));
    rd(`TMR_OFF_CNT_LO);
    chk("split lo reload", 16'h1, 16'(rd_v >= rl_lo));
    wr(`TMR_OFF_CTRL, 8'h6C);
    rdchk(`TMR_OFF_CTRL, 8'hEC, "split flags");
    wr(`TMR_OFF_CTRL, 8'hE8);
    rdchk(`TMR_OFF_CNT_HI, 8'h5D, "split hi reload");
    chk("split irq", 16'h1, 16'(timer_irq));
    wr(`TMR_OFF_CTRL, 8'h00);
    // divided-by-12 source over 120 cycles
    wr(`TMR_OFF_CLKSEL, 8'h00);
    wr(`TMR_OFF_CNT_LO, 8'h00);
    wr(`TMR_OFF_CNT_HI, 8'h00);
    wr(`TMR_OFF_CTRL, 8'h04);
    repeat (118) @(posedge mclk);
    wr(`TMR_OFF_CTRL, 8'h00);
    rdchk(`TMR_OFF_CNT_LO, 8'h0A, "slow count");
    // external source: a burst of 40 rising edges gives five ticks
    wr(`TMR_OFF_CNT_LO, 8'h00);
    wr(`TMR_OFF_CTRL, 8'h05);
    osc_on <= 1'b1;
    repeat (280) @(posedge mclk);
    osc_on <= 1'b0;
    repeat (10) @(posedge mclk);
    wr(`TMR_OFF_CTRL, 8'h00);
    rd(`TMR_OFF_CNT_LO);
    chk("ext count", 16'h1, 16'(rd_v >= 4 && rd_v <= 5));
    // capture on a comparator rise
    wr(`TMR_OFF_CLKSEL, 8'h01);
    wr(`TMR_OFF_CNT_LO, 8'h00);
    wr(`TMR_OFF_CTRL, 8'h14);
    repeat (20) @(posedge mclk);
    cmp_req <= 1'b1;
    repeat (10) @(posedge mclk);
    rdchk(`TMR_OFF_CTRL, 8'h94, "capture flag");
    rd(`TMR_OFF_RLD_LO);
    cap_v[7:0] = rd_v;
    rd(`TMR_OFF_RLD_HI);
    cap_v[15:8] = rd_v;
    rd(`TMR_OFF_CNT_LO);
    cnt_v[7:0] = rd_v;
    rd(`TMR_OFF_CNT_HI);
    cnt_v[15:8] = rd_v;
    chk("capture value", 16'h1, 16'(cap_v > 0 && cap_v < cnt_v));
    chk("capture irq", 16'h1, 16'(timer_irq));
    cmp_req <= 1'b0;
    // no capture while split is set
    wr(`TMR_OFF_CTRL, 8'h00);
    wr(`TMR_OFF_RLD_LO, 8'h3C);
    wr(`TMR_OFF_RLD_HI, 8'hC3);
    wr(`TMR_OFF_CTRL, 8'h18);
    repeat (4) @(posedge mclk);
    cmp_req <= 1'b1;
    repeat (10) @(posedge mclk);
    rdchk(`TMR_OFF_RLD_LO, 8'h3C, "split no capture lo");
    rdchk(`TMR_OFF_RLD_HI, 8'hC3, "split no capture hi");
    rd(`TMR_OFF_CTRL);
    chk("split no capture flag", 16'h0, 16'(rd_v[7]));
    complete_run();
  end
endmodule
